// ===== scf_pkg.sv
// Constants, state layout and reset values of the card status flag block
package scf_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] OFS_DATA_BUF = 8'hAC;
    localparam logic [7:0] OFS_STATUS   = 8'hAD;
    localparam logic [7:0] OFS_IDENT    = 8'hAE;
    localparam logic [7:0] OFS_ENABLE   = 8'hAF;

    // Bit positions, shared by status, identification and enable
    localparam int BIT_TBE     = 7;
    localparam int BIT_PRESENT = 6;
    localparam int BIT_OVC     = 5;
    localparam int BIT_VOLT    = 4;
    localparam int BIT_WT      = 3;
    localparam int BIT_SENT    = 2;
    localparam int BIT_RECV    = 1;
    localparam int BIT_PERR    = 0;

    // Reset values and writable bits
    localparam logic [7:0] STATUS_RST  = 8'h80;
    localparam logic [7:0] IDENT_RST   = 8'h00;
    localparam logic [7:0] ENABLE_RST  = 8'h00;
    localparam logic [7:0] ENABLE_MASK = 8'hBF;
    localparam logic [7:0] DATA_RST    = 8'h00;

    typedef struct packed {
        logic       tbe;
        logic       wt;
        logic       sent;
        logic       recv;
        logic       perr;
        logic [7:0] ident;
        logic [7:0] enable;
        logic       ovc_d;
        logic       vok_d;
        logic [7:0] rdata;
        logic [7:0] tx_data;
        logic       tx_wr;
    } scf_state_s;

    localparam scf_state_s STATE_RST = '{
        tbe:     STATUS_RST[BIT_TBE],
        wt:      STATUS_RST[BIT_WT],
        sent:    STATUS_RST[BIT_SENT],
        recv:    STATUS_RST[BIT_RECV],
        perr:    STATUS_RST[BIT_PERR],
        ident:   IDENT_RST,
        enable:  ENABLE_RST,
        ovc_d:   1'b0,
        vok_d:   1'b0,
        rdata:   DATA_RST,
        tx_data: DATA_RST,
        tx_wr:   1'b0
    };

endpackage

// ===== scf_status_irq.sv
// Card UART status flags, interrupt identification and priority logic
module scf_status_irq
(
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_B_I,
    input  wire logic       CE_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       IF_RESET_I,
    input  wire logic       REPEAT_MODE_I,
    input  wire logic       TX_LOAD_I,
    input  wire logic       TX_DONE_I,
    input  wire logic       TX_OK_I,
    input  wire logic       TX_LAST_I,
    input  wire logic       RX_DONE_I,
    input  wire logic       RX_PERR_I,
    input  wire logic       RX_LAST_I,
    input  wire logic [7:0] RX_DATA_I,
    input  wire logic       CARD_DETECT_I,
    input  wire logic       OVERCURRENT_I,
    input  wire logic       VOLTAGE_OK_I,
    input  wire logic       WT_EXPIRE_I,
    input  wire logic       WT_RELOAD_I,
    output logic      [7:0] TX_DATA_O,
    output logic            TX_WR_O,
    output logic            IRQ_O,
    output logic      [2:0] IRQ_ID_O
);

    scf_pkg::scf_state_s st;
    scf_pkg::scf_state_s next_st;

    logic       wr_data;
    logic       rd_data;
    logic       rd_status;
    logic       rd_ident;
    logic       ovc_rise;
    logic       volt_fall;
    logic       sent_set;
    logic       recv_set;
    logic       perr_set;
    logic [7:0] status_vec;
    logic [7:0] ident_set;
    logic [7:0] pending;

    // Highest pending bit wins; bit order equals the service order
    function automatic logic [2:0] prio_index(input logic [7:0] vec);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (vec[i])
            begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    assign wr_data   = WR_I && (ADDR_I == scf_pkg::OFS_DATA_BUF);
    assign rd_data   = RD_I && (ADDR_I == scf_pkg::OFS_DATA_BUF);
    assign rd_status = RD_I && (ADDR_I == scf_pkg::OFS_STATUS);
    assign rd_ident  = RD_I && (ADDR_I == scf_pkg::OFS_IDENT);

    // Edges, so a standing fault is reported once and not after every read
    assign ovc_rise  = OVERCURRENT_I && !st.ovc_d;
    assign volt_fall = st.vok_d && !VOLTAGE_OK_I;

    assign sent_set = TX_DONE_I && (!REPEAT_MODE_I || TX_OK_I);
    assign recv_set = RX_DONE_I
                      && (!REPEAT_MODE_I || !RX_PERR_I || RX_LAST_I);
    assign perr_set = REPEAT_MODE_I
                      ? ((RX_DONE_I && RX_PERR_I && RX_LAST_I)
                         || (TX_DONE_I && !TX_OK_I && TX_LAST_I))
                      : (RX_DONE_I && RX_PERR_I);

    always_comb
    begin
        status_vec = 8'h00;
        status_vec[scf_pkg::BIT_TBE]     = st.tbe;
        status_vec[scf_pkg::BIT_PRESENT] = CARD_DETECT_I;
        status_vec[scf_pkg::BIT_OVC]     = OVERCURRENT_I;
        status_vec[scf_pkg::BIT_VOLT]    = VOLTAGE_OK_I;
        status_vec[scf_pkg::BIT_WT]      = st.wt;
        status_vec[scf_pkg::BIT_SENT]    = st.sent;
        status_vec[scf_pkg::BIT_RECV]    = st.recv;
        status_vec[scf_pkg::BIT_PERR]    = st.perr;
    end

    always_comb
    begin
        ident_set = 8'h00;
        ident_set[scf_pkg::BIT_TBE]  = TX_LOAD_I;
        ident_set[scf_pkg::BIT_OVC]  = ovc_rise;
        ident_set[scf_pkg::BIT_VOLT] = volt_fall;
        ident_set[scf_pkg::BIT_WT]   = WT_EXPIRE_I;
        ident_set[scf_pkg::BIT_SENT] = sent_set;
        ident_set[scf_pkg::BIT_RECV] = recv_set;
        ident_set[scf_pkg::BIT_PERR] = perr_set;
    end

    always_comb
    begin
        next_st       = st;
        next_st.tx_wr = 1'b0;
        next_st.ovc_d = OVERCURRENT_I;
        next_st.vok_d = VOLTAGE_OK_I;

        if (WR_I && (ADDR_I == scf_pkg::OFS_ENABLE))
        begin
            next_st.enable = WDATA_I & scf_pkg::ENABLE_MASK;
        end
        if (wr_data)
        begin
            next_st.tx_data = WDATA_I;
            next_st.tx_wr   = 1'b1;
        end

        // Read data only in the cycle after the strobe, zero otherwise
        next_st.rdata = 8'h00;
        if (RD_I)
        begin
            case (ADDR_I)
                scf_pkg::OFS_DATA_BUF: next_st.rdata = RX_DATA_I;
                scf_pkg::OFS_STATUS:   next_st.rdata = status_vec;
                scf_pkg::OFS_IDENT:    next_st.rdata = st.ident;
                scf_pkg::OFS_ENABLE:   next_st.rdata = st.enable;
                default:               next_st.rdata = 8'h00;
            endcase
        end

        // Clears first, sets after, so a coinciding event is kept
        if (wr_data)
        begin
            next_st.tbe = 1'b0;
        end
        if (WT_RELOAD_I)
        begin
            next_st.wt = 1'b0;
        end
        if (rd_status)
        begin
            next_st.sent = 1'b0;
            next_st.perr = 1'b0;
        end
        if (rd_data)
        begin
            next_st.recv = 1'b0;
        end
        if (rd_ident)
        begin
            next_st.ident = 8'h00;
        end

        if (TX_LOAD_I)
        begin
            next_st.tbe = 1'b1;
        end
        if (WT_EXPIRE_I)
        begin
            next_st.wt = 1'b1;
        end
        if (sent_set)
        begin
            next_st.sent = 1'b1;
        end
        if (recv_set)
        begin
            next_st.recv = 1'b1;
        end
        if (perr_set)
        begin
            next_st.perr = 1'b1;
        end
        next_st.ident = next_st.ident | ident_set;

        // Interface reset returns every flag to its reset value
        if (IF_RESET_I)
        begin
            next_st.tbe   = scf_pkg::STATUS_RST[scf_pkg::BIT_TBE];
            next_st.wt    = scf_pkg::STATUS_RST[scf_pkg::BIT_WT];
            next_st.sent  = scf_pkg::STATUS_RST[scf_pkg::BIT_SENT];
            next_st.recv  = scf_pkg::STATUS_RST[scf_pkg::BIT_RECV];
            next_st.perr  = scf_pkg::STATUS_RST[scf_pkg::BIT_PERR];
            next_st.ident = scf_pkg::IDENT_RST;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st <= scf_pkg::STATE_RST;
        end
        else if (CE_I)
        begin
            st <= next_st;
        end
    end

    assign pending   = st.ident & st.enable;
    assign IRQ_O     = |pending;
    assign IRQ_ID_O  = prio_index(pending);
    assign RDATA_O   = st.rdata;
    assign TX_DATA_O = st.tx_data;
    assign TX_WR_O   = st.tx_wr;

    a_tbe_set: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && TX_LOAD_I && !IF_RESET_I) |=> st.tbe && st.ident[7])
        else $error("buffer empty flag or interrupt bit not set");

    a_tbe_clear: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && wr_data && !TX_LOAD_I && !IF_RESET_I) |=> !st.tbe)
        else $error("buffer empty flag not cleared by data write");

    a_status_read: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && rd_status) |=> RDATA_O == $past(status_vec)
            && RDATA_O[6] == $past(CARD_DETECT_I))
        else $error("status read value wrong");

    a_wt_clear: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && (WT_RELOAD_I || IF_RESET_I) && !WT_EXPIRE_I)
            |=> !st.wt)
        else $error("timeout flag survived reload");

    a_sent_repeat: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && !st.sent && TX_DONE_I && REPEAT_MODE_I && !TX_OK_I)
            |=> !st.sent)
        else $error("char sent set after failed repetition");

    a_recv_last: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && !IF_RESET_I && RX_DONE_I && REPEAT_MODE_I && RX_LAST_I)
            |=> st.recv && (st.perr == $past(RX_PERR_I) || $past(st.perr)))
        else $error("final repetition not reported");

    a_perr_tx_last: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && !IF_RESET_I && REPEAT_MODE_I && TX_DONE_I && !TX_OK_I
            && TX_LAST_I) |=> st.perr
            ##1 (st.perr || $past(rd_status) || $past(IF_RESET_I)))
        else $error("refused final transmission not flagged");

    a_ident_read: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && rd_ident && !IF_RESET_I && ident_set == 8'h00)
            |=> st.ident == 8'h00 && RDATA_O == $past(st.ident))
        else $error("identification read did not clear");

    a_volt_edge: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && !IF_RESET_I && VOLTAGE_OK_I) ##1
            (CE_I && !IF_RESET_I && !VOLTAGE_OK_I) |=> st.ident[4])
        else $error("voltage error not captured");

    a_irq_prio: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        IRQ_O |-> st.ident[IRQ_ID_O] && st.enable[IRQ_ID_O]
            && ((pending >> IRQ_ID_O) == 8'h01))
        else $error("interrupt index not highest enabled");

    a_sent_clear: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && rd_status && !sent_set && !perr_set)
            |=> !st.sent && !st.perr)
        else $error("status read did not clear sent and parity");

    a_live_bits: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && rd_status) |=> RDATA_O[5] == $past(OVERCURRENT_I)
            && RDATA_O[4] == $past(VOLTAGE_OK_I))
        else $error("supply status bits wrong in status read");

    a_wt_set: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && WT_EXPIRE_I && !IF_RESET_I) |=> st.wt && st.ident[3])
        else $error("timeout flag or interrupt bit not set");

    a_sent_set: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && TX_DONE_I && !REPEAT_MODE_I && !IF_RESET_I)
            |=> st.sent && st.ident[2])
        else $error("char sent flag or interrupt bit not set");

    a_recv_set: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && RX_DONE_I && !REPEAT_MODE_I && !IF_RESET_I)
            |=> st.recv && st.ident[1])
        else $error("char received flag or interrupt bit not set");

    a_recv_clear: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && rd_data && !recv_set) |=> !st.recv)
        else $error("data buffer read did not clear received flag");

    a_perr_set: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && RX_DONE_I && RX_PERR_I && !REPEAT_MODE_I && !IF_RESET_I)
            |=> st.perr && st.ident[0])
        else $error("parity flag or interrupt bit not set");

    a_ovc_edge: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && !IF_RESET_I && !OVERCURRENT_I) ##1
            (CE_I && !IF_RESET_I && OVERCURRENT_I) |=> st.ident[5])
        else $error("overcurrent not captured");

    a_if_reset: assert property (
        @(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CE_I && IF_RESET_I) |=> st.tbe && !st.wt && !st.sent
            && !st.recv && !st.perr && st.ident == 8'h00)
        else $error("interface reset left a flag set");

endmodule

// ===== scf_card_model.sv
// Card-side model: detect and supply lines, character attempt results
module scf_card_model
(
    input  wire logic       clk_i,
    output logic            tx_done_o,
    output logic            tx_ok_o,
    output logic            tx_last_o,
    output logic            rx_done_o,
    output logic            rx_perr_o,
    output logic            rx_last_o,
    output logic      [7:0] rx_data_o,
    output logic      [2:0] lines_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        {tx_done_o, tx_ok_o, tx_last_o} = 3'h0;
        {rx_done_o, rx_perr_o, rx_last_o} = 3'h0;
        rx_data_o = 8'h00;
        lines_o = 3'h0;
    end

    // Qualifiers flip after the pulse so a stale value is never trusted
    task automatic tx_attempt(input logic ok, input logic last);
        @(posedge clk_i);
        tx_done_o <= 1'b1;
        tx_ok_o   <= ok;
        tx_last_o <= last;
        @(posedge clk_i);
        tx_done_o <= 1'b0;
        tx_ok_o   <= ~ok;
        tx_last_o <= ~last;
    endtask

    // Received byte stays in the buffer until the next character
    task automatic rx_char(input logic perr, input logic last,
                           input logic [7:0] d);
        @(posedge clk_i);
        rx_done_o <= 1'b1;
        rx_perr_o <= perr;
        rx_last_o <= last;
        rx_data_o <= d;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        rx_perr_o <= ~perr;
        rx_last_o <= ~last;
    endtask

    // Lines are {detect, overcurrent, voltage ok}; no debouncing here
    task automatic set_lines(input logic [2:0] v);
        @(posedge clk_i);
        lines_o <= v;
        @(posedge clk_i);
    endtask
endmodule

// ===== smartcard_uart_status_irq_flags_bench.sv
// Self-checking bench for the card status flag and identification block
module smartcard_uart_status_irq_flags_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       rd = 1'b0;
    logic       wr = 1'b0;
    logic       rep = 1'b0;
    logic       run = 1'b1;
    logic       rd_q = 1'b0;
    logic       tbe = 1'b1;
    logic [3:0] ev = 4'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, tx_data, eid, dval, rxv;
    logic       tx_wr, irq, tx_done, tx_ok, tx_last;
    logic       rx_done, rx_perr, rx_last;
    logic [2:0] irq_id, lines, ln, nl;
    logic [7:0] expq[$];
    logic [2:0] cs[6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7, 3'h4};
    logic [3:0] ce[6] = '{4'h0, 4'h1, 4'h4, 4'h0, 4'h3, 4'h2};
    int         n_mismatch = 0;
    int         checked = 0;
    int         seed = 56;
    int         rv;

    always #50 clk = ~clk;

    scf_card_model card (.clk_i(clk), .tx_done_o(tx_done), .tx_ok_o(tx_ok),
        .tx_last_o(tx_last), .rx_done_o(rx_done), .rx_perr_o(rx_perr),
        .rx_last_o(rx_last), .rx_data_o(rxv), .lines_o(lines));

    scf_status_irq DUT (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(run),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .IF_RESET_I(ev[3]), .REPEAT_MODE_I(rep),
        .TX_LOAD_I(ev[0]), .TX_DONE_I(tx_done), .TX_OK_I(tx_ok),
        .TX_LAST_I(tx_last), .RX_DONE_I(rx_done), .RX_PERR_I(rx_perr),
        .RX_LAST_I(rx_last), .RX_DATA_I(rxv), .CARD_DETECT_I(lines[2]),
        .OVERCURRENT_I(lines[1]), .VOLTAGE_OK_I(lines[0]),
        .WT_EXPIRE_I(ev[1]), .WT_RELOAD_I(ev[2]), .TX_DATA_O(tx_data),
        .TX_WR_O(tx_wr), .IRQ_O(irq), .IRQ_ID_O(irq_id));

    task automatic cmp(input logic [7:0] e, input logic [7:0] a);
        checked++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask

    task automatic chk_irq(input logic [3:0] e);
        @(negedge clk);
        cmp({4'h0, e}, {4'h0, irq, irq_id});
    endtask

    function automatic logic [7:0] st(input logic [3:0] lo);
        return {tbe, ln, lo};
    endfunction

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk)
        if (rd_q && expq.size() > 0)
            cmp(expq.pop_front(), rdata);

    initial
    begin
        #300000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        ln = 3'h0;
        eid = 8'h00;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(scf_pkg::OFS_STATUS, 8'h80);
        rd_reg(scf_pkg::OFS_IDENT, 8'h00);
        rd_reg(8'h12, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rv = $random(seed);
            nl = rv[2:0];
            eid[5] = eid[5] | (nl[1] & ~ln[1]);
            eid[4] = eid[4] | (~nl[0] & ln[0]);
            ln = nl;
            card.set_lines(ln);
            rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        end
        chk_irq(4'h0);
        ln = 3'h5;
        card.set_lines(ln);
        rd_reg(scf_pkg::OFS_IDENT, eid);
        rv = $random(seed);
        dval = rv[7:0];
        wr_reg(scf_pkg::OFS_DATA_BUF, dval);
        @(negedge clk);
        cmp({7'h00, tx_wr}, 8'h01);
        cmp(tx_data, dval);
        @(negedge clk);
        cmp({7'h00, tx_wr}, 8'h00);
        tbe = 1'b0;
        rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        pulse(4'h1);
        tbe = 1'b1;
        chk_irq(4'h0);
        wr_reg(scf_pkg::OFS_ENABLE, 8'hFF);
        chk_irq(4'hF);
        rd_reg(scf_pkg::OFS_ENABLE, 8'hBF);
        rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        rd_reg(scf_pkg::OFS_IDENT, 8'h80);
        chk_irq(4'h0);
        rd_reg(scf_pkg::OFS_IDENT, 8'h00);
        card.rx_char(1'b1, 1'b0, dval);
        chk_irq(4'h9);
        card.tx_attempt(1'b1, 1'b0);
        chk_irq(4'hA);
        pulse(4'h2);
        chk_irq(4'hB);
        ln = 3'h4;
        card.set_lines(ln);
        chk_irq(4'hC);
        ln = 3'h6;
        card.set_lines(ln);
        chk_irq(4'hD);
        pulse(4'h1);
        chk_irq(4'hF);
        rd_reg(scf_pkg::OFS_STATUS, st(4'hF));
        rd_reg(scf_pkg::OFS_IDENT, 8'hBF);
        rd_reg(scf_pkg::OFS_STATUS, st(4'hA));
        rd_reg(scf_pkg::OFS_DATA_BUF, dval);
        rd_reg(scf_pkg::OFS_STATUS, st(4'h8));
        pulse(4'h4);
        rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        ln = 3'h5;
        card.set_lines(ln);
        rep <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            if (cs[i][2])
                card.rx_char(cs[i][1], cs[i][0], dval);
            else
                card.tx_attempt(cs[i][1], cs[i][0]);
            rd_reg(scf_pkg::OFS_STATUS, st(ce[i]));
            rd_reg(scf_pkg::OFS_DATA_BUF, dval);
        end
        rd_reg(scf_pkg::OFS_IDENT, 8'h07);
        rep <= 1'b0;
        pulse(4'h2);
        card.tx_attempt(1'b1, 1'b0);
        wr_reg(scf_pkg::OFS_DATA_BUF, dval);
        pulse(4'h8);
        rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        rd_reg(scf_pkg::OFS_IDENT, 8'h00);
        rd_reg(scf_pkg::OFS_ENABLE, 8'hBF);
        // Events while the enable is low must be lost
        run <= 1'b0;
        pulse(4'h3);
        run <= 1'b1;
        chk_irq(4'h0);
        rd_reg(scf_pkg::OFS_STATUS, st(4'h0));
        rd_reg(scf_pkg::OFS_IDENT, 8'h00);
        repeat (2) @(posedge clk);
        give_verdict();
    end
endmodule
